/* File: core/nve_pkg.sv */
// nve_pkg: constants, register map and state types of the data array access block
// assumes a single core clock at NVE_CLK_HZ and byte-wide register access
package nve_pkg;

  // clock rate of the core
  localparam int NVE_CLK_HZ = 25_000_000;

  // register indices on the plain register port
  localparam logic [2:0] NVE_OFF_DATA = 3'h0;
  localparam logic [2:0] NVE_OFF_ADDR = 3'h1;
  localparam logic [2:0] NVE_OFF_CTRL = 3'h2;
  localparam logic [2:0] NVE_OFF_UNLOCK = 3'h3;
  localparam logic [2:0] NVE_OFF_FLAG = 3'h4;

  // control register field positions
  localparam int NVE_CTRL_RD = 0;
  localparam int NVE_CTRL_WR = 1;
  localparam int NVE_CTRL_WRITE_ENABLE_BIT = 2;
  localparam int NVE_CTRL_WERR = 3;
  // flag register: write complete bit
  localparam int NVE_FLAG_DONE = 7;

  // reset and erase values
  localparam logic [7:0] NVE_RST_BYTE = 8'h00;
  localparam logic [7:0] NVE_ERASED = 8'hFF;

  // unlock keys and exact cycle spacing between the sequence steps
  localparam logic [7:0] NVE_KEY1 = 8'h55;
  localparam logic [7:0] NVE_KEY2 = 8'hAA;
  localparam logic [2:0] NVE_UNLOCK_GAP = 3'h2;

  // power-up write lockout
  localparam int NVE_PWRT_MS = 64;
  localparam int NVE_PWRT_CYCLES = (NVE_CLK_HZ / 1000) * NVE_PWRT_MS;
  // nominal erase plus program time, real parts vary
  localparam int NVE_WRITE_TIME_US = 5000;
  localparam int NVE_WRITE_CYCLES = (NVE_CLK_HZ / 1_000_000) * NVE_WRITE_TIME_US;

  // write engine states, gray along idle, erase, program
  typedef enum logic [1:0] {
    NVE_IDLE = 2'h0,
    NVE_ERASE = 2'h1,
    NVE_PROG = 2'h3
  } nve_state_t;

  // unlock tracker stages
  typedef enum logic [1:0] {
    NVE_LK_NONE = 2'h0,
    NVE_LK_KEY1 = 2'h1,
    NVE_LK_KEY2 = 2'h3
  } nve_lock_t;

endpackage

/* File: core/nve_data_eeprom.sv */
// nve_data_eeprom: byte-wide non-volatile data array with register access and write engine
// assumes a processor on the same clock driving one-cycle strobes, reset causes from pins
//
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/1ns

// three-flop input synchroniser with agreement filter
module nve_sync3 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_resetn,
  // raw and filtered levels
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_level
);
  logic [WIDTH-1:0] s1_q; // first stage, read only by s2_q
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  // shift chain; level follows once stages two and three agree
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      o_level <= '0;
    end else begin
      s1_q <= i_async;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          o_level[i] <= s3_q[i];
        end
      end
    end
  end
endmodule

module nve_data_eeprom import nve_pkg::*; #(
  parameter int P_DEPTH = 256,
  parameter int P_PWRT_CYCLES = NVE_PWRT_CYCLES,
  parameter int P_WRITE_CYCLES = NVE_WRITE_CYCLES
) (
  // clock and power-on reset
  input wire logic i_clock,
  input wire logic i_resetn,
  // register port
  input wire logic [2:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  // warm reset causes, active high levels
  input wire logic i_pin_reset,
  input wire logic i_wdt_reset,
  input wire logic i_bor_reset,
  // protection and external programmer read
  input wire logic i_data_protect,
  input wire logic i_prog_rd,
  input wire logic [7:0] i_prog_addr,
  output logic [7:0] o_prog_rdata,
  // status
  output logic o_write_busy,
  output logic o_write_done_flag
);
  localparam int ERASE_CYC = P_WRITE_CYCLES / 2;
  localparam int PROG_CYC = P_WRITE_CYCLES - ERASE_CYC;
  localparam int TW = $clog2(P_WRITE_CYCLES + 1);
  localparam int PW = $clog2(P_PWRT_CYCLES + 1);

  logic [7:0] mem [P_DEPTH]; // the array itself, never reset
  logic [3:0] ext_lvl; // filtered reset causes and protect strap
  logic warm; // any warm reset cause held
  logic prot; // data protection active
  logic [7:0] data_q; // data register
  logic [7:0] addr_q; // address register
  logic write_enable_bit_q; // write enable
  logic werr_q; // write error
  logic rd_q; // read start, one-cycle pulse
  logic done_q; // write complete flag
  nve_state_t st_q; // write engine state
  logic [TW-1:0] tmr_q; // write phase timer
  logic [7:0] wad_q; // latched write address
  logic [7:0] wdat_q; // latched write data
  logic [PW-1:0] pwrt_q; // power-up timer
  logic pwrt_done_q; // power-up lockout over
  nve_lock_t lk_q; // unlock sequence stage
  logic [2:0] lk_cnt_q; // cycles since last sequence step
  logic [7:0] rd_byte; // array byte at address register
  logic wr_ctrl; // software write to control
  logic rd_fire; // read start accepted
  logic wr_go; // write start accepted
  logic erase_end; // last erase cycle
  logic prog_end; // last program cycle

  // reset causes and strap come from outside the clock domain
  nve_sync3 #(
    .WIDTH(4)
  ) u_sync (
    .i_clock(i_clock),
    .i_resetn(i_resetn),
    .i_async({i_data_protect, i_bor_reset, i_wdt_reset, i_pin_reset}),
    .o_level(ext_lvl)
  );

  assign warm = |ext_lvl[2:0];
  assign prot = ext_lvl[3];
  assign rd_byte = mem[addr_q];
  assign wr_ctrl = i_reg_wr && (i_reg_addr == NVE_OFF_CTRL) && !warm;
  // a read is refused while the array is being written
  assign rd_fire = wr_ctrl && i_reg_wdata[NVE_CTRL_RD] && (st_q == NVE_IDLE);
  // start needs enable already set, full unlock, lockout over, engine idle
  assign wr_go = wr_ctrl && i_reg_wdata[NVE_CTRL_WR] && write_enable_bit_q
    && (lk_q == NVE_LK_KEY2) && (lk_cnt_q == NVE_UNLOCK_GAP)
    && pwrt_done_q && (st_q == NVE_IDLE);
  assign erase_end = (st_q == NVE_ERASE) && (tmr_q == TW'(ERASE_CYC - 1));
  assign prog_end = (st_q == NVE_PROG) && (tmr_q == TW'(PROG_CYC - 1));
  assign o_write_busy = (st_q != NVE_IDLE);
  assign o_write_done_flag = done_q;

  // power-up timer, runs once after power-on reset only
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      pwrt_q <= '0;
      pwrt_done_q <= 1'b0;
    end else if (!pwrt_done_q) begin
      if (pwrt_q == PW'(P_PWRT_CYCLES - 1)) begin
        pwrt_done_q <= 1'b1;
      end else begin
        pwrt_q <= pwrt_q + PW'(1);
      end
    end
  end

  // unlock tracker; any other write or a wrong spacing drops the sequence
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      lk_q <= NVE_LK_NONE;
      lk_cnt_q <= 3'h0;
    end else if (warm) begin
      lk_q <= NVE_LK_NONE;
      lk_cnt_q <= 3'h0;
    end else if (i_reg_wr) begin
      lk_cnt_q <= 3'h1;
      if (i_reg_addr == NVE_OFF_UNLOCK && i_reg_wdata == NVE_KEY1) begin
        lk_q <= NVE_LK_KEY1;
      end else if (i_reg_addr == NVE_OFF_UNLOCK && i_reg_wdata == NVE_KEY2
          && lk_q == NVE_LK_KEY1 && lk_cnt_q == NVE_UNLOCK_GAP) begin
        lk_q <= NVE_LK_KEY2;
      end else begin
        lk_q <= NVE_LK_NONE; // start write consumes it too
      end
    end else if (lk_q != NVE_LK_NONE) begin
      // late step counts as a deviation
      if (lk_cnt_q == NVE_UNLOCK_GAP) begin
        lk_q <= NVE_LK_NONE;
      end else begin
        lk_cnt_q <= lk_cnt_q + 3'h1;
      end
    end
  end

  // data register: warm clear, read load, software write
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      data_q <= NVE_RST_BYTE;
    end else if (warm) begin
      data_q <= NVE_RST_BYTE;
    end else if (rd_fire) begin
      data_q <= rd_byte;
    end else if (i_reg_wr && i_reg_addr == NVE_OFF_DATA) begin
      data_q <= i_reg_wdata;
    end
  end

  // address register
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      addr_q <= NVE_RST_BYTE;
    end else if (warm) begin
      addr_q <= NVE_RST_BYTE;
    end else if (i_reg_wr && i_reg_addr == NVE_OFF_ADDR) begin
      addr_q <= i_reg_wdata;
    end
  end

  // control bits: enable, error, read pulse
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      write_enable_bit_q <= 1'b0;
      werr_q <= 1'b0;
      rd_q <= 1'b0;
    end else if (warm) begin
      write_enable_bit_q <= 1'b0;
      rd_q <= 1'b0;
      // a write cut short leaves its mark
      if (st_q != NVE_IDLE) begin
        werr_q <= 1'b1;
      end
    end else begin
      rd_q <= rd_fire;
      if (wr_ctrl) begin
        // clearing enable here leaves a running write untouched
        write_enable_bit_q <= i_reg_wdata[NVE_CTRL_WRITE_ENABLE_BIT];
        werr_q <= i_reg_wdata[NVE_CTRL_WERR];
      end
    end
  end

  // write engine: erase phase then program phase, timed internally
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      st_q <= NVE_IDLE;
      tmr_q <= '0;
      wad_q <= NVE_RST_BYTE;
      wdat_q <= NVE_RST_BYTE;
    end else if (warm) begin
      st_q <= NVE_IDLE; // abort, the byte may stay erased
      tmr_q <= '0;
    end else begin
      case (st_q)
        NVE_IDLE: begin
          tmr_q <= '0;
          if (wr_go) begin
            // latch operands so later register edits cannot corrupt them
            wad_q <= addr_q;
            wdat_q <= data_q;
            st_q <= NVE_ERASE;
          end
        end
        NVE_ERASE: begin
          if (erase_end) begin
            tmr_q <= '0;
            st_q <= NVE_PROG;
          end else begin
            tmr_q <= tmr_q + TW'(1);
          end
        end
        NVE_PROG: begin
          if (prog_end) begin
            tmr_q <= '0;
            st_q <= NVE_IDLE;
          end else begin
            tmr_q <= tmr_q + TW'(1);
          end
        end
        default: begin
          st_q <= NVE_IDLE;
          tmr_q <= '0;
        end
      endcase
    end
  end

  // array update, no reset since contents are non-volatile
  always_ff @(posedge i_clock) begin
    if (!warm && erase_end) begin
      mem[wad_q] <= NVE_ERASED;
    end else if (!warm && prog_end) begin
      mem[wad_q] <= wdat_q;
    end
  end

  // completion flag; hardware set wins over a software clear
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      done_q <= 1'b0;
    end else if (!warm && prog_end) begin
      done_q <= 1'b1;
    end else if (i_reg_wr && i_reg_addr == NVE_OFF_FLAG) begin
      done_q <= i_reg_wdata[NVE_FLAG_DONE];
    end
  end

  // register read data, valid only in the cycle after the strobe
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        NVE_OFF_DATA: o_reg_rdata <= data_q;
        NVE_OFF_ADDR: o_reg_rdata <= addr_q;
        NVE_OFF_CTRL: o_reg_rdata <= {4'h0, werr_q, write_enable_bit_q, o_write_busy, rd_q};
        NVE_OFF_UNLOCK: o_reg_rdata <= 8'h00;
        NVE_OFF_FLAG: o_reg_rdata <= {done_q, 7'h00};
        default: o_reg_rdata <= 8'h00;
      endcase
    end else begin
      o_reg_rdata <= 8'h00;
    end
  end

  // programmer port sees zeros while protection is on
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_prog_rdata <= 8'h00;
    end else if (i_prog_rd && !prot) begin
      o_prog_rdata <= mem[i_prog_addr];
    end else begin
      o_prog_rdata <= 8'h00;
    end
  end

  // checks on the behaviour above
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);

  AST_RD_LOADS_DATA: assert property (
    rd_fire |=> (data_q == $past(rd_byte)))
    else $error("read start did not load addressed byte");

  AST_CTRL_HIGH_ZERO: assert property (
    (i_reg_rd && i_reg_addr == NVE_OFF_CTRL) |=> (o_reg_rdata[7:4] == 4'h0))
    else $error("control high bits not zero");

  AST_UNLOCK_ZERO: assert property (
    (i_reg_rd && i_reg_addr == NVE_OFF_UNLOCK) |=> (o_reg_rdata == 8'h00))
    else $error("unlock location did not read zero");

  AST_START_NEEDS_KEYS: assert property (
    $rose(o_write_busy) |-> ($past(lk_q) == NVE_LK_KEY2 && $past(write_enable_bit_q)
      && $past(lk_cnt_q) == NVE_UNLOCK_GAP))
    else $error("write began without enable and unlock");

  AST_PWRT_LOCKOUT: assert property (
    !pwrt_done_q |-> (st_q == NVE_IDLE))
    else $error("write during power-up lockout");

  AST_WR_STICKS: assert property (
    (o_write_busy && wr_ctrl && !prog_end && !i_reg_wdata[NVE_CTRL_WR])
      |=> o_write_busy)
    else $error("software cleared write start");

  AST_WRITE_ENABLE_BIT_NO_ABORT: assert property (
    (o_write_busy && wr_ctrl && !prog_end && !i_reg_wdata[NVE_CTRL_WRITE_ENABLE_BIT])
      |=> (o_write_busy && !write_enable_bit_q))
    else $error("clearing enable disturbed write");

  AST_WARM_ERR: assert property (
    (warm && o_write_busy) |=> (werr_q && !o_write_busy))
    else $error("interrupted write left no error");

  AST_WARM_CLEAR: assert property (
    warm |=> (data_q == NVE_RST_BYTE && addr_q == NVE_RST_BYTE && !write_enable_bit_q))
    else $error("warm reset left registers loaded");

  AST_DONE_SET: assert property (
    (prog_end && !warm) |=> (done_q && !o_write_busy
      && mem[$past(wad_q)] == $past(wdat_q)))
    else $error("write end without flag or data");

  AST_ERASE_FIRST: assert property (
    (erase_end && !warm) |=> (st_q == NVE_PROG && mem[wad_q] == NVE_ERASED))
    else $error("program without prior erase");

  AST_PROT_ZERO: assert property (
    (i_prog_rd && prot) |=> (o_prog_rdata == 8'h00))
    else $error("protected array visible to programmer");

endmodule

/* File: tb/nve_data_eeprom_tb.sv */
// nve_data_eeprom_tb: self-checking bench for the data array access block
// assumes one 25 MHz clock, shortened power-up and write counts, bench drives all ports
`timescale 1ns/1ns
module nve_data_eeprom_tb import nve_pkg::*;;
  localparam int PWRT = 20; // shortened power-up lockout
  localparam int WCYC = 8; // shortened write time
  // stimulus
  logic i_clock = 1'h0;
  logic i_resetn = 1'h0;
  logic [2:0] i_reg_addr = 3'h0;
  logic [7:0] i_reg_wdata = 8'h00;
  logic i_reg_wr = 1'h0;
  logic i_reg_rd = 1'h0;
  logic i_pin_reset = 1'h0;
  logic i_wdt_reset = 1'h0;
  logic i_bor_reset = 1'h0;
  logic i_data_protect = 1'h0;
  logic i_prog_rd = 1'h0;
  logic [7:0] i_prog_addr = 8'h00;
  // observed outputs
  logic [7:0] o_reg_rdata;
  logic [7:0] o_prog_rdata;
  logic o_write_busy;
  logic o_write_done_flag;
  int bad_count = 0; // mismatches
  int samples_checked = 0; // comparisons
  int seed = 82; // fixed so a failing run repeats
  logic [7:0] a, d, v;

  nve_data_eeprom #(.P_DEPTH(256), .P_PWRT_CYCLES(PWRT), .P_WRITE_CYCLES(WCYC))
    nve_data_eeprom_inst (.i_clock(i_clock), .i_resetn(i_resetn), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata), .i_pin_reset(i_pin_reset), .i_wdt_reset(i_wdt_reset),
    .i_bor_reset(i_bor_reset), .i_data_protect(i_data_protect), .i_prog_rd(i_prog_rd),
    .i_prog_addr(i_prog_addr), .o_prog_rdata(o_prog_rdata), .o_write_busy(o_write_busy),
    .o_write_done_flag(o_write_done_flag));

  // free-running core clock, 40 ns period
  initial begin
    forever #20 i_clock = ~i_clock;
  end

  // compare one byte, count it, report a mismatch
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // expected control byte from error, enable and write-start bits; read start never shows
  function automatic logic [7:0] ctrl_exp(input logic err, input logic en, input logic go);
    ctrl_exp = {4'h0, err, en, go, 1'h0};
  endfunction

  // one-cycle register write; consecutive calls land two cycles apart
  task automatic wr(input logic [2:0] ra, input logic [7:0] wd);
    @(posedge i_clock);
    i_reg_wr <= 1'h1;
    i_reg_addr <= ra;
    i_reg_wdata <= wd;
    @(posedge i_clock);
    i_reg_wr <= 1'h0;
  endtask

  // one-cycle register read; data is sampled in the single cycle it stands
  task automatic rd(input logic [2:0] ra, output logic [7:0] rv);
    @(posedge i_clock);
    i_reg_rd <= 1'h1;
    i_reg_addr <= ra;
    @(posedge i_clock);
    i_reg_rd <= 1'h0;
    #1 rv = o_reg_rdata;
  endtask

  // programmer read port, answer one cycle later
  task automatic prog(input logic [7:0] pa, output logic [7:0] pv);
    @(posedge i_clock);
    i_prog_rd <= 1'h1;
    i_prog_addr <= pa;
    @(posedge i_clock);
    i_prog_rd <= 1'h0;
    #1 pv = o_prog_rdata;
  endtask

  // unlock steps with an optional extra gap, then the start write
  task automatic seq(input logic [7:0] k1, input int gap, input logic [7:0] c);
    wr(NVE_OFF_UNLOCK, k1);
    repeat (gap) @(posedge i_clock);
    wr(NVE_OFF_UNLOCK, NVE_KEY2);
    wr(NVE_OFF_CTRL, c);
    @(posedge i_clock);
    #1;
  endtask

  // load data and address, enable, then the exact unlock sequence
  task automatic start(input logic [7:0] wa, input logic [7:0] wd);
    wr(NVE_OFF_DATA, wd);
    wr(NVE_OFF_ADDR, wa);
    wr(NVE_OFF_CTRL, 8'h04);
    seq(NVE_KEY1, 0, 8'h06);
  endtask

  // bounded wait for the engine to go idle
  task automatic wait_idle();
    int n;
    n = 0;
    while (o_write_busy !== 1'h0 && n < 200) begin
      @(posedge i_clock);
      n++;
    end
    if (n >= 200) check("idle wait", 8'h01, 8'h00);
  endtask

  // load address, start a read, fetch the data register
  task automatic readback(input logic [7:0] ra, output logic [7:0] rv);
    wr(NVE_OFF_ADDR, ra);
    wr(NVE_OFF_CTRL, 8'h01);
    rd(NVE_OFF_DATA, rv);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // watchdog: the whole run needs a few hundred cycles
  initial begin
    #(40 * 20000);
    bad_count++;
    end_of_test();
  end

  initial begin
    repeat (2) @(posedge i_clock);
    i_resetn <= 1'h1;
    // power-up value before any control write touches it
    rd(NVE_OFF_CTRL, v);
    check("ctrl power-up", v, ctrl_exp(1'h0, 1'h0, 1'h0));
    // start attempt inside the power-up lockout must be ignored
    start(8'h10, 8'h5A);
    check("busy in lockout", {7'h0, o_write_busy}, 8'h00);
    repeat (PWRT) @(posedge i_clock);
    $display("test lockout done");
    // reset values, unmapped and storage-less places
    wr(NVE_OFF_CTRL, 8'h00);
    rd(NVE_OFF_CTRL, v);
    check("ctrl reset", v, 8'h00);
    rd(NVE_OFF_UNLOCK, v);
    check("unlock read", v, 8'h00);
    for (int i = 5; i < 8; i++) begin
      rd(i[2:0], v);
      check("unmapped read", v, 8'h00);
    end
    wr(NVE_OFF_CTRL, 8'hF4);
    rd(NVE_OFF_CTRL, v);
    check("ctrl high bits", v, 8'h04);
    $display("test registers done");
    // random writes with the two end addresses first
    for (int i = 0; i < 6; i++) begin
      a = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(seed));
      d = 8'($random(seed));
      start(a, d);
      check("busy after start", {7'h0, o_write_busy}, 8'h01);
      rd(NVE_OFF_CTRL, v);
      check("ctrl while busy", v, ctrl_exp(1'h0, 1'h1, 1'h1));
      wait_idle();
      check("done flag", {7'h0, o_write_done_flag}, 8'h01);
      rd(NVE_OFF_FLAG, v);
      check("flag reg", v, 8'h80);
      wr(NVE_OFF_FLAG, 8'h00);
      // let the clear settle before looking at the flag
      #1;
      check("flag cleared", {7'h0, o_write_done_flag}, 8'h00);
      rd(NVE_OFF_CTRL, v);
      check("ctrl after write", v, 8'h04);
      readback(a, v);
      check("read back", v, d);
      prog(a, v);
      check("prog read", v, d);
    end
    $display("test writes done");
    // data register holds its value across an address change
    wr(NVE_OFF_ADDR, a ^ 8'h01);
    rd(NVE_OFF_DATA, v);
    check("data hold", v, d);
    // refused starts: no enable, wrong first key, late second key
    wr(NVE_OFF_CTRL, 8'h00);
    seq(NVE_KEY1, 0, 8'h02);
    check("busy without enable", {7'h0, o_write_busy}, 8'h00);
    wr(NVE_OFF_CTRL, 8'h04);
    seq(NVE_KEY2, 0, 8'h06);
    check("busy wrong key", {7'h0, o_write_busy}, 8'h00);
    seq(NVE_KEY1, 1, 8'h06);
    check("busy wrong gap", {7'h0, o_write_busy}, 8'h00);
    readback(a, v);
    check("byte untouched", v, d);
    $display("test refusals done");
    // clearing control while busy neither clears start nor aborts
    start(8'h33, 8'hC3);
    wr(NVE_OFF_CTRL, 8'h00);
    // look after the edge that took the clear, not in its time step
    #1;
    check("busy after clear", {7'h0, o_write_busy}, 8'h01);
    wait_idle();
    wr(NVE_OFF_FLAG, 8'h00);
    readback(8'h33, v);
    check("write survives", v, 8'hC3);
    $display("test enable clear done");
    // each warm reset cause cuts a write short
    for (int k = 0; k < 3; k++) begin
      start(8'h44, 8'h3C);
      {i_bor_reset, i_wdt_reset, i_pin_reset} <= 3'h1 << k;
      repeat (4) @(posedge i_clock);
      {i_bor_reset, i_wdt_reset, i_pin_reset} <= 3'h0;
      repeat (6) @(posedge i_clock);
      rd(NVE_OFF_CTRL, v);
      check("error flag", v, ctrl_exp(1'h1, 1'h0, 1'h0));
      rd(NVE_OFF_DATA, v);
      check("data cleared", v, 8'h00);
      rd(NVE_OFF_ADDR, v);
      check("addr cleared", v, 8'h00);
      wr(NVE_OFF_CTRL, 8'h00);
      wr(NVE_OFF_FLAG, 8'h00);
    end
    $display("test warm reset done");
    // protection hides the array from the programmer only
    i_data_protect <= 1'h1;
    repeat (5) @(posedge i_clock);
    prog(8'h33, v);
    check("prog protected", v, 8'h00);
    readback(8'h33, v);
    check("cpu protected", v, 8'hC3);
    $display("test protect done");
    end_of_test();
  end
endmodule
